/* File: logic/uecp_defines.svh */
// Register offsets, field positions, reset values and sizes of the port
`ifndef UECP_DEFINES_SVH
`define UECP_DEFINES_SVH

`define UECP_OFF_SETUP_BASE 8'h00
`define UECP_OFF_EP_STATUS 8'h20
`define UECP_OFF_EP_CONTROL 8'h21
`define UECP_OFF_IRQ_STATUS 8'h22
`define UECP_OFF_IRQ_ENABLE 8'h23
`define UECP_OFF_MAX_PACKET 8'h24
`define UECP_OFF_RX_COUNT 8'h25
`define UECP_OFF_POLARITY 8'h26
`define UECP_OFF_PIN_CONFIG 8'h27
`define UECP_OFF_PIN_STATUS 8'h28
`define UECP_OFF_FIFO_PORT 8'h29

`define UECP_STAT_RX_READY 0
`define UECP_STAT_SETUP_READY 2
`define UECP_STAT_TX_READY 4
`define UECP_IRQ_SETUP 0
`define UECP_IRQ_RX 6
`define UECP_IRQ_TX 7
`define UECP_POL_IRQ_OUT 0
`define UECP_POL_DREQ0 1
`define UECP_POL_DREQ1 2
`define UECP_POL_DACK0 3
`define UECP_POL_DACK1 4
`define UECP_CFG_PULLUP_MODE 0
`define UECP_CFG_PULLUP_ON 1

`define UECP_RST_POLARITY 8'h00
`define UECP_RST_PIN_CONFIG 2'h0
`define UECP_RST_MAX_PACKET 8'h08
`define UECP_FIFO_DEPTH 32
`define UECP_FIFO_AW 5
`define UECP_FIFO_FULL 6'h20
`define UECP_CNT_MAX 6'h3F

`endif

/* File: logic/uecp_fifo_mem.sv */
// Byte store of the control endpoint FIFO with registered read data
`timescale 1ns/1ps
`include "uecp_defines.svh"
module uecp_fifo_mem (
    // Clock
    input wire logic mclk,
    input wire logic ce,
    // Write port
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [4:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [`UECP_FIFO_DEPTH];

    always_ff @(posedge mclk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

/* File: logic/uecp_pkg.sv */
// Types shared by the control endpoint port
package uecp_pkg;

    // Local bus pins as sampled
    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
        logic addr_format_select;
        logic ale;
        logic [7:0] addr;
        logic [7:0] adLow;
        logic [1:0] dack;
    } uecp_pins_t;

    // Byte stream and events from the serial engine
    typedef struct packed {
        logic byteValid;
        logic [7:0] byteData;
        logic setupPkt;
        logic pktEnd;
        logic txPop;
        logic txDone;
        logic busReset;
        logic lineIndet;
    } uecp_sie_t;

    typedef struct packed {
        uecp_pins_t pinMeta;
        uecp_pins_t pinSync;
        uecp_pins_t pinPrev;
        logic [7:0] latchedAddr;
        logic [7:0][7:0] setupB;
        logic [2:0] setupIdx;
        logic rxReady;
        logic setupReady;
        logic txReady;
        logic stall;
        logic [7:0] irqStat;
        logic [7:0] irqEn;
        logic [7:0] maxPacket;
        logic [5:0] rxCount;
        logic [5:0] pktCnt;
        logic [7:0] polarity;
        logic [1:0] pinCfg;
        logic [4:0] wrPtr;
        logic [4:0] rdPtr;
        logic [5:0] fifoCnt;
        logic [15:0] busDataOut;
        logic busOeN;
        logic irqOut;
        logic [1:0] dmaReq;
        logic lpOut;
        logic lpOeN;
        logic [7:0] txByte;
    } uecp_state_t;

endpackage

/* File: logic/uecp_top.sv */
// Local bus port and control endpoint logic of the USB device controller
//
// Contract
// R1: Indeterminate lines block writes to USB-reset registers
// R2: Interrupt and DMA requests default active low
// R3: DMA acknowledges default active high, selectable
// R4: Address latch strobe is active high
// R5: Shared pin is latch strobe or pull-up control
// R6: Sixteen-bit data bus, upper byte on high lines
// R7: Low byte carries address and data when multiplexed
// R8: Format select picks separate or multiplexed address
// R9: Master drives chip select and strobes active low
// R10: All control transfers run on endpoint zero
// R11: One 32-byte FIFO for both directions
// R12: Control read, write and no-data transfers supported
// R13: Setup packet sets ready flag and status bit
// R14: Setup interrupt gated by enable bit zero
// R15: Packet-ready events reported in status bits six, seven
// R16: Packet-ready interrupts gated by enable bits six, seven
// R17: Host issues eleven standard requests on default pipe
// R18: Eight setup bytes held in read-only registers
// R19: Receive count holds last packet length, six bits
`timescale 1ns/1ps
`include "uecp_defines.svh"
module uecp_top (
    // Clock, reset, clock enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Local bus pins, raw
    input wire uecp_pkg::uecp_pins_t pinsIn,
    input wire logic [7:0] dataHighByteIn,
    output logic [7:0] muxedAddrDataLowOut,
    output logic muxedAddrDataLowOeN,
    output logic [7:0] dataHighByteOut,
    output logic dataHighByteOeN,
    // Shared latch / pull-up pin, output side
    output logic latchOrPullupPinOut,
    output logic latchOrPullupPinOeN,
    // Request outputs
    output logic irqOut,
    output logic [1:0] dmaRequestOut,
    // Serial engine side
    input wire uecp_pkg::uecp_sie_t sie,
    output logic [7:0] sieTxByte,
    output logic ep0TxArmed,
    output logic ep0Stall,
    output logic [7:0] ep0MaxPacket
);
    uecp_pkg::uecp_state_t st_r;
    uecp_pkg::uecp_state_t st_nxt;
    logic memWe;
    logic [4:0] memWaddr;
    logic [7:0] memWdata;
    logic [7:0] memRdata;
    logic rdStart;
    logic wrEnd;
    logic aleMode;
    logic [7:0] rdAddr;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [1:0] dackAct;
    logic irqAct;

    // Edges come from the second and third sampling stages only
    assign rdStart = st_r.pinPrev.rdN && !st_r.pinSync.rdN &&
        !st_r.pinSync.csN;
    assign wrEnd = !st_r.pinPrev.wrN && st_r.pinSync.wrN &&
        !st_r.pinPrev.csN;
    assign aleMode = !st_r.pinCfg[`UECP_CFG_PULLUP_MODE];
    assign rdAddr = st_r.pinSync.addr_format_select ? st_r.latchedAddr : // see R8
        st_r.pinSync.addr;
    assign wrAddr = st_r.pinPrev.addr_format_select ? st_r.latchedAddr : // see R8
        st_r.pinPrev.addr;
    assign wrData = st_r.pinPrev.adLow; // see R7
    assign dackAct = st_r.pinSync.dack ^ // see R3
        {st_r.polarity[`UECP_POL_DACK1], st_r.polarity[`UECP_POL_DACK0]};
    assign irqAct = |(st_r.irqStat & st_r.irqEn); // see R14 see R16

    function automatic logic [15:0] regRead(
        input logic [7:0] a,
        input uecp_pkg::uecp_state_t q,
        input logic [7:0] head,
        input logic [1:0] dk
    );
        logic [15:0] d;
        d = 16'h0000;
        if (a[7:3] == 5'h00) begin
            d[7:0] = q.setupB[a[2:0]]; // see R18
            // Even offsets also return the next byte on the upper lines
            if (!a[0]) begin
                d[15:8] = q.setupB[a[2:0] + 3'h1];
            end
        end else begin
            case (a)
                `UECP_OFF_EP_STATUS: begin
                    d[`UECP_STAT_RX_READY] = q.rxReady;
                    d[`UECP_STAT_SETUP_READY] = q.setupReady;
                    d[`UECP_STAT_TX_READY] = q.txReady;
                end
                `UECP_OFF_EP_CONTROL: d[0] = q.stall;
                `UECP_OFF_IRQ_STATUS: d[7:0] = q.irqStat;
                `UECP_OFF_IRQ_ENABLE: d[7:0] = q.irqEn;
                `UECP_OFF_MAX_PACKET: d[7:0] = q.maxPacket;
                `UECP_OFF_RX_COUNT: d[5:0] = q.rxCount;
                `UECP_OFF_POLARITY: d[7:0] = q.polarity;
                `UECP_OFF_PIN_CONFIG: d[1:0] = q.pinCfg;
                `UECP_OFF_PIN_STATUS: d[1:0] = dk;
                `UECP_OFF_FIFO_PORT: d[7:0] = head;
                default: d = 16'h0000;
            endcase
        end
        return d;
    endfunction

    always_comb begin
        logic push;
        logic pop;
        logic usbWr;
        push = 1'h0;
        pop = 1'h0;
        usbWr = 1'h0;
        st_nxt = st_r;
        memWe = 1'h0;
        memWaddr = st_r.wrPtr;
        memWdata = wrData;

        st_nxt.pinMeta = pinsIn;
        st_nxt.pinSync = st_r.pinMeta;
        st_nxt.pinPrev = st_r.pinSync;
        if (aleMode && st_r.pinSync.ale) begin // see R4 see R7
            st_nxt.latchedAddr = st_r.pinSync.adLow;
        end
        // Register reads; a FIFO read pops unless the engine pops
        if (rdStart) begin // see R6
            st_nxt.busDataOut = regRead(rdAddr, st_r, memRdata, dackAct);
            if (rdAddr == `UECP_OFF_FIFO_PORT && st_r.fifoCnt != 6'h00 &&
                !sie.txPop) begin
                pop = 1'h1;
            end
        end
        st_nxt.busOeN = !(!st_r.pinSync.csN && !st_r.pinSync.rdN);
        // Register writes; USB-reset registers locked on bad lines
        usbWr = wrEnd && !sie.lineIndet; // see R1
        if (usbWr) begin
            case (wrAddr)
                `UECP_OFF_EP_STATUS: begin
                    if (wrData[`UECP_STAT_RX_READY]) begin
                        st_nxt.rxReady = 1'h0;
                    end
                    if (wrData[`UECP_STAT_SETUP_READY]) begin
                        st_nxt.setupReady = 1'h0;
                    end
                    if (wrData[`UECP_STAT_TX_READY]) begin // see R12
                        st_nxt.txReady = 1'h1;
                    end
                end
                `UECP_OFF_EP_CONTROL: st_nxt.stall = wrData[0];
                `UECP_OFF_IRQ_STATUS: st_nxt.irqStat = st_r.irqStat & ~wrData;
                `UECP_OFF_IRQ_ENABLE: st_nxt.irqEn = wrData;
                `UECP_OFF_MAX_PACKET: st_nxt.maxPacket = wrData;
                default: st_nxt.stall = st_nxt.stall;
            endcase
        end
        if (wrEnd) begin
            case (wrAddr)
                `UECP_OFF_POLARITY: st_nxt.polarity = wrData;
                `UECP_OFF_PIN_CONFIG: st_nxt.pinCfg = wrData[1:0];
                default: st_nxt.pinCfg = st_nxt.pinCfg;
            endcase
        end

        // Engine traffic: all of it belongs to endpoint zero
        if (sie.byteValid && sie.setupPkt) begin // see R10
            st_nxt.setupB[st_r.setupIdx] = sie.byteData; // see R18
            st_nxt.setupIdx = st_r.setupIdx + 3'h1;
        end else if (sie.byteValid) begin
            if (st_r.fifoCnt != `UECP_FIFO_FULL) begin // see R11
                push = 1'h1;
                memWdata = sie.byteData;
            end
            if (st_r.pktCnt != `UECP_CNT_MAX) begin
                st_nxt.pktCnt = st_r.pktCnt + 6'h01;
            end
        end else if (wrEnd && wrAddr == `UECP_OFF_FIFO_PORT &&
            st_r.fifoCnt != `UECP_FIFO_FULL) begin
            push = 1'h1;
        end
        if (sie.txPop && st_r.fifoCnt != 6'h00) begin
            pop = 1'h1;
            st_nxt.txByte = memRdata;
        end
        if (push) begin
            memWe = 1'h1;
            st_nxt.wrPtr = st_r.wrPtr + 5'h01;
        end
        if (pop) begin
            st_nxt.rdPtr = st_r.rdPtr + 5'h01;
        end
        if (push && !pop) begin
            st_nxt.fifoCnt = st_r.fifoCnt + 6'h01;
        end else if (pop && !push) begin
            st_nxt.fifoCnt = st_r.fifoCnt - 6'h01;
        end
        // Hardware sets come after software clears, so a set wins
        if (sie.pktEnd && sie.setupPkt) begin // see R13
            st_nxt.setupReady = 1'h1;
            st_nxt.irqStat[`UECP_IRQ_SETUP] = 1'h1;
            st_nxt.setupIdx = 3'h0;
            // New request drops any stale stage data
            st_nxt.txReady = 1'h0;
            st_nxt.stall = 1'h0;
            st_nxt.wrPtr = 5'h00;
            st_nxt.rdPtr = 5'h00;
            st_nxt.fifoCnt = 6'h00;
            memWe = 1'h0;
        end else if (sie.pktEnd) begin // see R15 see R19
            st_nxt.rxReady = 1'h1;
            st_nxt.irqStat[`UECP_IRQ_RX] = 1'h1;
            st_nxt.rxCount = st_r.pktCnt;
            st_nxt.pktCnt = 6'h00;
        end
        if (sie.txDone) begin // see R15
            st_nxt.txReady = 1'h0;
            st_nxt.irqStat[`UECP_IRQ_TX] = 1'h1;
        end
        if (sie.busReset) begin
            st_nxt.setupIdx = 3'h0;
            st_nxt.rxReady = 1'h0;
            st_nxt.setupReady = 1'h0;
            st_nxt.txReady = 1'h0;
            st_nxt.stall = 1'h0;
            st_nxt.irqStat = 8'h00;
            st_nxt.irqEn = 8'h00;
            st_nxt.maxPacket = `UECP_RST_MAX_PACKET;
            st_nxt.rxCount = 6'h00;
            st_nxt.pktCnt = 6'h00;
            st_nxt.wrPtr = 5'h00;
            st_nxt.rdPtr = 5'h00;
            st_nxt.fifoCnt = 6'h00;
            memWe = 1'h0;
        end

        st_nxt.irqOut = st_r.polarity[`UECP_POL_IRQ_OUT] ? irqAct : // see R2
            !irqAct;
        // No DMA channel is served, so both requests rest inactive
        st_nxt.dmaReq = ~{st_r.polarity[`UECP_POL_DREQ1],
            st_r.polarity[`UECP_POL_DREQ0]};
        st_nxt.lpOeN = aleMode; // see R5
        st_nxt.lpOut = !aleMode && st_r.pinCfg[`UECP_CFG_PULLUP_ON];
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.pinMeta <= '1;
            st_r.pinSync <= '1;
            st_r.pinPrev <= '1;
            st_r.maxPacket <= `UECP_RST_MAX_PACKET;
            st_r.polarity <= `UECP_RST_POLARITY;
            st_r.pinCfg <= `UECP_RST_PIN_CONFIG;
            st_r.busOeN <= 1'h1;
            st_r.irqOut <= 1'h1;
            st_r.dmaReq <= 2'h3;
            st_r.lpOeN <= 1'h1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    uecp_fifo_mem fifoMem (
        .mclk(mclk),
        .ce(ce),
        .we(memWe && ce),
        .waddr(memWaddr),
        .wdata(memWdata),
        .raddr(st_nxt.rdPtr),
        .rdata(memRdata)
    );

    assign muxedAddrDataLowOut = st_r.busDataOut[7:0];
    assign muxedAddrDataLowOeN = st_r.busOeN;
    assign dataHighByteOut = st_r.busDataOut[15:8];
    assign dataHighByteOeN = st_r.busOeN;
    assign latchOrPullupPinOut = st_r.lpOut;
    assign latchOrPullupPinOeN = st_r.lpOeN;
    assign irqOut = st_r.irqOut;
    assign dmaRequestOut = st_r.dmaReq;
    assign sieTxByte = st_r.txByte;
    assign ep0TxArmed = st_r.txReady;
    assign ep0Stall = st_r.stall;
    assign ep0MaxPacket = st_r.maxPacket;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    usb_lock_a: assert property ( // see R1
        ce && wrEnd && sie.lineIndet && !sie.busReset &&
        wrAddr == `UECP_OFF_MAX_PACKET |=>
        st_r.maxPacket == $past(st_r.maxPacket))
        else $error("max packet written while lines indeterminate");
    reset_idle_a: assert property ( // see R2
        $rose(rst_n) |-> irqOut && dmaRequestOut == 2'h3)
        else $error("request outputs not inactive high after reset");
    irq_gate_a: assert property ( // see R14
        ce && !st_r.polarity[`UECP_POL_IRQ_OUT] && st_r.irqStat[0] &&
        st_r.irqEn[0] |=> !irqOut)
        else $error("enabled setup interrupt not driven low");
    ale_latch_a: assert property ( // see R4
        ce && aleMode && st_r.pinSync.ale |=>
        st_r.latchedAddr == $past(st_r.pinSync.adLow))
        else $error("address not latched while strobe high");
    pullup_pin_a: assert property ( // see R5
        ce && !aleMode |=> !latchOrPullupPinOeN &&
        latchOrPullupPinOut == $past(st_r.pinCfg[`UECP_CFG_PULLUP_ON]))
        else $error("pull-up control not driven");
    bus_drive_a: assert property ( // see R6
        ce && rdStart |=> !muxedAddrDataLowOeN && !dataHighByteOeN)
        else $error("read data not driven");
    fifo_bound_a: assert property ( // see R11
        st_r.fifoCnt <= `UECP_FIFO_FULL)
        else $error("fifo count beyond depth");
    setup_flag_a: assert property ( // see R13
        ce && sie.pktEnd && sie.setupPkt && !sie.busReset |=>
        st_r.setupReady && st_r.irqStat[`UECP_IRQ_SETUP])
        else $error("setup ready not raised");
    rx_count_a: assert property ( // see R19
        ce && sie.pktEnd && !sie.setupPkt && !sie.busReset |=>
        st_r.irqStat[`UECP_IRQ_RX] && st_r.rxCount == $past(st_r.pktCnt))
        else $error("receive count or ready wrong");
    tx_done_a: assert property ( // see R15
        ce && sie.txDone && !sie.busReset |=>
        !ep0TxArmed && st_r.irqStat[`UECP_IRQ_TX])
        else $error("transmit done not reported");
    setup_store_a: assert property ( // see R18
        ce && sie.byteValid && sie.setupPkt && !sie.busReset |=>
        st_r.setupB[$past(st_r.setupIdx)] == $past(sie.byteData))
        else $error("setup byte not stored");
endmodule

/* File: sim/tb_uecp_top.sv */
// Self-checking bench of the control endpoint port
`timescale 1ns/1ps
`include "uecp_defines.svh"
module tb_uecp_top;
    logic mclk;
    logic rst_n;
    uecp_pkg::uecp_pins_t pins;
    uecp_pkg::uecp_pins_t pinsW;
    uecp_pkg::uecp_sie_t sie;
    logic [7:0] lowOut;
    logic lowOeN;
    logic [7:0] highOut;
    logic highOeN;
    logic lpOut;
    logic lpOeN;
    logic irqOut;
    logic [1:0] dmaReq;
    logic [7:0] txByte;
    logic txArmed;
    logic stall;
    logic [7:0] maxPkt;
    logic [7:0] rd;
    logic [63:0] got;
    int failures;
    int checked;

    // Wire levels where the port drives shared pins
    always_comb begin
        pinsW = pins;
        if (!lowOeN) begin
            pinsW.adLow = lowOut;
        end
        if (!lpOeN) begin
            pinsW.ale = lpOut;
        end
    end

    uecp_top dut (
        .mclk(mclk), .rst_n(rst_n), .ce(1'h1), .pinsIn(pinsW),
        .dataHighByteIn(8'h00), .muxedAddrDataLowOut(lowOut),
        .muxedAddrDataLowOeN(lowOeN), .dataHighByteOut(highOut),
        .dataHighByteOeN(highOeN), .latchOrPullupPinOut(lpOut),
        .latchOrPullupPinOeN(lpOeN), .irqOut(irqOut),
        .dmaRequestOut(dmaReq), .sie(sie), .sieTxByte(txByte),
        .ep0TxArmed(txArmed), .ep0Stall(stall), .ep0MaxPacket(maxPkt)
    );

    uecp_host_model host (
        .mclk(mclk), .sie(sie), .sieTxByte(txByte)
    );

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic busWr(input logic [7:0] a, input logic [7:0] d);
        pins.addr = a;
        pins.adLow = d;
        pins.csN = 1'h0;
        pins.wrN = 1'h0;
        cyc(4);
        pins.wrN = 1'h1;
        cyc(2);
        pins.csN = 1'h1;
        cyc(6);
    endtask

    task automatic busRd(input logic [7:0] a, output logic [7:0] d);
        pins.addr = a;
        pins.csN = 1'h0;
        pins.rdN = 1'h0;
        cyc(6);
        chk("drive", {lowOeN, highOeN}, 2'h0);
        d = lowOut;
        pins.rdN = 1'h1;
        pins.csN = 1'h1;
        cyc(6);
        chk("release", {lowOeN, highOeN}, 2'h3);
    endtask

    // Address presented on the low lines with the strobe high
    task automatic latch(input logic [7:0] a);
        pins.adLow = a;
        pins.ale = 1'h1;
        cyc(4);
        pins.ale = 1'h0;
        cyc(2);
    endtask

    task automatic t_reset();
        chk("irq idle", irqOut, 1'h1);
        chk("dreq idle", dmaReq, 2'h3);
        busRd(`UECP_OFF_MAX_PACKET, rd);
        chk("maxpkt", {rd, maxPkt}, 16'h0808);
        busRd(`UECP_OFF_POLARITY, rd);
        chk("polarity", rd, 8'h00);
        busRd(8'hF0, rd);
        chk("unmapped", rd, 8'h00);
    endtask

    task automatic t_setup();
        host.sendPkt(1'h1, 64'h0012_0000_0100_0680, 8);
        cyc(3);
        chk("irq masked", irqOut, 1'h1);
        busRd(`UECP_OFF_EP_STATUS, rd);
        chk("setup flag", rd[2], 1'h1);
        busRd(`UECP_OFF_IRQ_STATUS, rd);
        chk("setup stat", rd[0], 1'h1);
        busWr(8'h01, 8'hAA);
        for (int k = 0; k < 8; k++) begin
            busRd(8'(k), rd);
            chk("setup byte", rd, 8'(64'h12000001000680 >> (8*k)));
        end
        busRd(8'h00, rd);
        chk("upper byte", highOut, 8'h06);
        busWr(`UECP_OFF_IRQ_ENABLE, 8'h01);
        cyc(3);
        chk("irq setup", irqOut, 1'h0);
        busWr(`UECP_OFF_IRQ_STATUS, 8'h01);
        busWr(`UECP_OFF_EP_STATUS, 8'h04);
        chk("irq clear", irqOut, 1'h1);
    endtask

    task automatic t_out();
        busWr(`UECP_OFF_IRQ_ENABLE, 8'h40);
        host.sendPkt(1'h0, 64'h55_4433_2211, 5);
        cyc(3);
        chk("irq rx", irqOut, 1'h0);
        busRd(`UECP_OFF_IRQ_STATUS, rd);
        chk("rx stat", rd, 8'h40);
        busRd(`UECP_OFF_RX_COUNT, rd);
        chk("rx count", rd, 8'h05);
        for (int k = 0; k < 5; k++) begin
            busRd(`UECP_OFF_FIFO_PORT, rd);
            chk("rx fifo", rd, 8'h11 * (k + 1));
        end
        host.sendPkt(1'h0, 64'h0, 40);
        busRd(`UECP_OFF_RX_COUNT, rd);
        chk("rx count 40", rd, 8'h28);
        busWr(`UECP_OFF_IRQ_STATUS, 8'hFF);
        busWr(`UECP_OFF_EP_STATUS, 8'h05);
        chk("irq rx clr", irqOut, 1'h1);
    endtask

    task automatic t_in();
        busWr(`UECP_OFF_EP_CONTROL, 8'h01);
        chk("stall set", stall, 1'h1);
        host.sendPkt(1'h1, 64'h0040_0000_0100_0680, 8);
        cyc(2);
        chk("stall clr", stall, 1'h0);
        busWr(`UECP_OFF_IRQ_STATUS, 8'hFF);
        busWr(`UECP_OFF_EP_STATUS, 8'h04);
        busWr(`UECP_OFF_IRQ_ENABLE, 8'h80);
        for (int k = 0; k < 3; k++) begin
            busWr(`UECP_OFF_FIFO_PORT, 8'hA1 + 8'(k * 17));
        end
        busWr(`UECP_OFF_EP_STATUS, 8'h10);
        chk("tx armed", txArmed, 1'h1);
        host.popBytes(3, got);
        chk("tx data", got[23:0], 24'hC3B2A1);
        cyc(2);
        chk("tx done", {txArmed, irqOut}, 2'h0);
        busRd(`UECP_OFF_IRQ_STATUS, rd);
        chk("tx stat", rd, 8'h80);
        busWr(`UECP_OFF_IRQ_STATUS, 8'hFF);
    endtask

    task automatic t_pol();
        busWr(`UECP_OFF_POLARITY, 8'h07);
        chk("inv req", {irqOut, dmaReq}, 3'h0);
        pins.dack = 2'h1;
        busRd(`UECP_OFF_PIN_STATUS, rd);
        chk("dack high", rd[1:0], 2'h1);
        busWr(`UECP_OFF_POLARITY, 8'h18);
        busRd(`UECP_OFF_PIN_STATUS, rd);
        chk("dack low", rd[1:0], 2'h2);
        busWr(`UECP_OFF_POLARITY, 8'h00);
        pins.dack = 2'h0;
    endtask

    task automatic t_refuse();
        host.setLine(1'h1);
        busWr(`UECP_OFF_MAX_PACKET, 8'h40);
        chk("indet wr", maxPkt, 8'h08);
        host.setLine(1'h0);
        busWr(`UECP_OFF_MAX_PACKET, 8'h40);
        chk("line ok wr", maxPkt, 8'h40);
        host.pulseReset();
        chk("bus reset", maxPkt, 8'h08);
    endtask

    task automatic t_muxed();
        pins.addr_format_select = 1'h1;
        latch(`UECP_OFF_MAX_PACKET);
        busWr(8'hFF, 8'h20);
        chk("muxed wr", maxPkt, 8'h20);
        latch(`UECP_OFF_MAX_PACKET);
        busRd(8'hFF, rd);
        chk("muxed rd", rd, 8'h20);
        pins.addr_format_select = 1'h0;
        busRd(`UECP_OFF_MAX_PACKET, rd);
        chk("separate rd", rd, 8'h20);
    endtask

    task automatic t_pullup();
        busWr(`UECP_OFF_PIN_CONFIG, 8'h03);
        chk("pullup on", {lpOeN, lpOut}, 2'h1);
        busWr(`UECP_OFF_PIN_CONFIG, 8'h00);
        chk("latch mode", lpOeN, 1'h1);
    endtask

    task automatic report_and_stop();
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        report_and_stop();
    end

    initial begin
        failures = 0;
        checked = 0;
        rst_n = 1'h0;
        pins = '0;
        pins.csN = 1'h1;
        pins.rdN = 1'h1;
        pins.wrN = 1'h1;
        repeat (10) @(posedge mclk);
        #1;
        rst_n = 1'h1;
        cyc(3);
        t_reset();
        t_setup();
        t_out();
        t_in();
        t_pol();
        t_refuse();
        t_muxed();
        t_pullup();
        report_and_stop();
    end
endmodule

/* File: sim/uecp_host_model.sv */
// Host-side serial engine stand-in for endpoint zero traffic
`timescale 1ns/1ps
module uecp_host_model (
    // Clock
    input wire logic mclk,
    // Engine interface of the port
    output uecp_pkg::uecp_sie_t sie,
    input wire logic [7:0] sieTxByte
);
    initial begin
        sie = '0;
    end

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic setLine(input logic indet);
        sie.lineIndet = indet;
    endtask

    task automatic pulseReset();
        sie.busReset = 1'h1;
        tick();
        sie.busReset = 1'h0;
    endtask

    // Bytes cycle through d when n exceeds eight
    task automatic sendPkt(input logic setup, input logic [63:0] d,
                           input int n);
        sie.setupPkt = setup;
        for (int k = 0; k < n; k++) begin
            sie.byteValid = 1'h1;
            sie.byteData = d[8*(k%8) +: 8];
            tick();
        end
        sie.byteValid = 1'h0;
        sie.byteData = ~sie.byteData;
        sie.pktEnd = 1'h1;
        tick();
        sie.pktEnd = 1'h0;
        sie.setupPkt = 1'h0;
    endtask

    task automatic popBytes(input int n, output logic [63:0] got);
        got = '0;
        sie.txPop = 1'h1;
        for (int k = 0; k < n; k++) begin
            tick();
            got[8*k +: 8] = sieTxByte;
        end
        sie.txPop = 1'h0;
        sie.txDone = 1'h1;
        tick();
        sie.txDone = 1'h0;
    endtask
endmodule
